// ### inc/seg_pkg.sv
// package: constants, types and helpers for the latched segment display block
package seg_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned SCAN_MS = 10;
  localparam int unsigned SCAN_CYC = SCAN_MS * CLK_MHZ * 1000;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SRC1 = 8'h04;
  localparam logic [7:0] A_SRC2 = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_SEGSRC = 8'h10;
  localparam logic [7:0] A_SEGDST = 8'h14;
  localparam logic [7:0] A_PERIOD = 8'h18;
  localparam logic [7:0] A_ARW = 8'h1C;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CB_DRIVE = 0;
  localparam int CB_POL = 1;
  localparam int CB_SINK = 2;
  localparam int CB_ARW = 3;
  localparam int CB_N = 4;
  localparam int CB_AN = 8;
  localparam int SB_DONE = 0;
  localparam int SB_ERR = 1;
  localparam int SB_POS = 4;
  localparam int SB_SEL = 8;
  localparam logic [15:0] MAX_BCD = 16'h270F;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [1:0] SEL_RST = 2'h3;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // scan states, one-hot
  typedef enum logic [1:0] {
    SC_IDLE = 2'b01,
    SC_RUN = 2'b10
  } scan_state_t;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // normal pattern in bits 6..0, inverted set has bit 7 high
  function automatic logic [7:0] seg_code(input logic [3:0] h, input logic inv);
    logic [6:0] p;
    p = 7'h00;
    case (h)
      4'h0: p = 7'h3F;
      4'h1: p = 7'h06;
      4'h2: p = 7'h5B;
      4'h3: p = 7'h4F;
      4'h4: p = 7'h66;
      4'h5: p = 7'h6D;
      4'h6: p = 7'h7D;
      4'h7: p = 7'h27;
      4'h8: p = 7'h7F;
      4'h9: p = 7'h6F;
      4'hA: p = 7'h77;
      4'hB: p = 7'h7C;
      4'hC: p = 7'h39;
      4'hD: p = 7'h5E;
      4'hE: p = 7'h79;
      default: p = 7'h71;
    endcase
    return inv ? {1'b1, ~p} : {1'b0, p};
  endfunction : seg_code

  // binary to four bcd digits by shift and add three
  function automatic logic [15:0] bin2bcd(input logic [15:0] b);
    logic [31:0] sh;
    sh = {16'h0000, b};
    for (int i = 0; i < 16; i++) begin
      for (int j = 0; j < 4; j++) begin
        if (sh[16 + 4 * j +: 4] >= 4'h5) begin
          sh[16 + 4 * j +: 4] = sh[16 + 4 * j +: 4] + 4'h3;
        end
      end
      sh = {sh[30:0], 1'b0};
    end
    return sh[31:16];
  endfunction : bin2bcd

  // digit of a bcd word at a position, position 0 is the units
  function automatic logic [3:0] nib_at(input logic [15:0] w, input logic [1:0] pos);
    return w[{pos, 2'b00} +: 4];
  endfunction : nib_at

  function automatic logic [3:0] onehot(input logic [1:0] pos);
    return 4'h1 << pos;
  endfunction : onehot

endpackage : seg_pkg

// ### inc/seg_if.sv
// interface: decoder and arrow-key entry links inside the display block
`timescale 1ns/1ns
`default_nettype none
interface seg_if;
  logic [3:0] nib;
  logic pol;
  logic [7:0] seg;
  logic en;
  logic [3:0] key;
  logic [1:0] pos;
  logic wr;
  logic [15:0] wdata;
  logic [15:0] word;
  logic [3:0] dig;
  logic [1:0] sel;

  modport dec (input nib, pol, output seg);
  modport dec_user (output nib, pol, input seg);
  modport arw (input en, key, pos, wr, wdata, output word, dig, sel);
  modport arw_user (output en, key, pos, wr, wdata, input word, dig, sel);
endinterface : seg_if
`default_nettype wire

// ### hdl/hex_segment_decode.sv
// hex digit to seven-segment byte decoder with selectable polarity
`timescale 1ns/1ns
`default_nettype none
module hex_segment_decode (
  seg_if.dec d // nibble and polarity in, segment byte out
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // only the low nibble reaches here, upper source bits never matter
  always_comb begin
    d.seg = seg_pkg::seg_code(d.nib, d.pol);
  end
endmodule : hex_segment_decode
`default_nettype wire

// ### hdl/arrow_key_entry.sv
// arrow-key data entry: digit select and bcd digit increment/decrement
`timescale 1ns/1ns
`default_nettype none
module arrow_key_entry (
  input wire logic clk_sys, // system clock
  input wire logic srst, // synchronous reset, active high
  seg_if.arw a // keys, load port and edited word
);
  typedef struct packed {
    logic [15:0] word;
    logic [1:0] sel;
    logic [3:0] kprev;
  } arw_state_t;

  arw_state_t s_r;
  arw_state_t s_nxt;
  logic [3:0] rise;
  logic [3:0] d;

  // ---------------------------------------------------------------
  // key handling
  // ---------------------------------------------------------------
  // fixed key priority stands in for first-pressed-wins; keys are
  // acted on at their rising edge only, so a held key steps once
  always_comb begin
    s_nxt = s_r;
    rise = a.key & ~s_r.kprev;
    d = seg_pkg::nib_at(s_r.word, s_r.sel);
    s_nxt.kprev = a.key;
    if (a.wr) begin
      s_nxt.word = a.wdata;
    end else if (a.en) begin
      if (rise[0]) begin
        s_nxt.sel = s_r.sel - 2'h1;
      end else if (rise[1]) begin
        s_nxt.sel = s_r.sel + 2'h1;
      end else if (rise[2]) begin
        s_nxt.word[{s_r.sel, 2'b00} +: 4] = (d >= 4'h9) ? 4'h0 : d + 4'h1;
      end else if (rise[3]) begin
        s_nxt.word[{s_r.sel, 2'b00} +: 4] = (d == 4'h0 || d > 4'h9) ? 4'h9 : d - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_r <= '{word: seg_pkg::WORD_RST, sel: seg_pkg::SEL_RST, kprev: 4'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // edited word and the digit at the arrow entry scan position
  assign a.word = s_r.word;
  assign a.sel = s_r.sel;
  assign a.dig = seg_pkg::nib_at(s_r.word, a.pos);
endmodule : arrow_key_entry
`default_nettype wire

// ### hdl/latched_segment_display.sv
// top: latched bcd display driver with apb registers, decoder and arrow entry
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module latched_segment_display #(
  parameter int unsigned SCAN_CYC = seg_pkg::SCAN_CYC // clocks per computation cycle
) (
  input wire logic clk_sys, // system clock, 125 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [3:0] key_in, // arrow keys: lower, higher, up, down
  output logic [3:0] group1_data_outputs, // first group bcd data pins
  output logic [3:0] group2_data_outputs, // second group bcd data pins
  output logic [3:0] digit_strobe_outputs, // shared digit strobe pins
  output logic [7:0] arrow_scan_outputs, // arrow entry data and strobe pins
  output logic sequence_done_flag, // sticky, four digits sent
  output logic error_flag // sticky, word out of bcd range
);
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic drive;
    logic pol;
    logic sink;
    logic arw_en;
    logic [2:0] n;
    logic [1:0] an;
    logic [15:0] src1;
    logic [15:0] src2;
    logic [15:0] dst;
    logic [23:0] period;
    logic [23:0] cnt;
    seg_pkg::scan_state_t st;
    logic [1:0] pos;
    logic [1:0] apos;
    logic done;
    logic err;
    logic [3:0] g1;
    logic [3:0] g2;
    logic [3:0] strb;
    logic [7:0] arw;
    logic [3:0] pin_g1;
    logic [3:0] pin_g2;
    logic [3:0] pin_strb;
    logic [7:0] pin_arw;
  } top_state_t;

  top_state_t s_r;
  top_state_t s_nxt;
  top_state_t s_rst;
  logic tick;
  logic setup;
  logic acc;
  logic [15:0] bcd1;
  logic [15:0] bcd2;
  logic bad;
  logic mapped;
  logic [31:0] rd;
  logic [3:0] act_d;
  logic [3:0] act_s;
  logic [7:0] act_a;

  seg_if u_if ();

  // ---------------------------------------------------------------
  // sub-blocks
  // ---------------------------------------------------------------
  hex_segment_decode u_dec (
    .d(u_if.dec)
  );

  arrow_key_entry u_arw (
    .clk_sys(clk_sys),
    .srst(srst),
    .a(u_if.arw)
  );

  // decoder sees the low nibble of the write data only
  assign u_if.nib = pwdata[3:0];
  assign u_if.pol = s_r.pol;
  assign u_if.en = s_r.arw_en;
  assign u_if.key = key_in;
  assign u_if.pos = s_r.apos;
  assign u_if.wr = acc && pwrite && paddr == seg_pkg::A_ARW;
  assign u_if.wdata = pwdata[15:0];

  // ---------------------------------------------------------------
  // computation cycle timing
  // ---------------------------------------------------------------
  // a period of zero or one ticks every clock; the 10 ms floor is
  // left to software, the hardware does not enforce it
  assign tick = ({8'h00, s_r.cnt} + 32'h0000_0001) >= {8'h00, s_r.period};

  // ---------------------------------------------------------------
  // conversion and range check
  // ---------------------------------------------------------------
  assign bcd1 = seg_pkg::bin2bcd(s_r.src1);
  assign bcd2 = seg_pkg::bin2bcd(s_r.src2);
  assign bad = (s_r.src1 > seg_pkg::MAX_BCD)
    || (s_r.n[2] && s_r.src2 > seg_pkg::MAX_BCD);

  // ---------------------------------------------------------------
  // apb phases
  // ---------------------------------------------------------------
  // no wait state: the answer is built at the setup edge so that
  // prdata, pready and pslverr all come straight from flops
  assign setup = psel && !penable;
  assign acc = psel && penable && s_r.pready;

  // read mux and address decode
  always_comb begin
    rd = seg_pkg::RD_ZERO;
    mapped = 1'b1;
    case (paddr)
      seg_pkg::A_CTRL: begin
        rd[seg_pkg::CB_DRIVE] = s_r.drive;
        rd[seg_pkg::CB_POL] = s_r.pol;
        rd[seg_pkg::CB_SINK] = s_r.sink;
        rd[seg_pkg::CB_ARW] = s_r.arw_en;
        rd[seg_pkg::CB_N +: 3] = s_r.n;
        rd[seg_pkg::CB_AN +: 2] = s_r.an;
      end
      seg_pkg::A_SRC1: rd[15:0] = s_r.src1;
      seg_pkg::A_SRC2: rd[15:0] = s_r.src2;
      seg_pkg::A_STAT: begin
        rd[seg_pkg::SB_DONE] = s_r.done;
        rd[seg_pkg::SB_ERR] = s_r.err;
        rd[seg_pkg::SB_POS +: 2] = s_r.pos;
        rd[seg_pkg::SB_SEL +: 2] = u_if.sel;
      end
      seg_pkg::A_SEGSRC: rd = seg_pkg::RD_ZERO;
      seg_pkg::A_SEGDST: rd[15:0] = s_r.dst;
      seg_pkg::A_PERIOD: rd[23:0] = s_r.period;
      seg_pkg::A_ARW: rd[15:0] = u_if.word;
      default: mapped = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // pin levels
  // ---------------------------------------------------------------
  // internal value is flipped once for the monitor's logic (setting
  // bits) and once more for a sinking output stage
  always_comb begin
    act_d = seg_pkg::nib_at(bcd1, s_r.pos) ^ {4{s_r.n[1]}};
    act_s = seg_pkg::onehot(s_r.pos) ^ {4{s_r.n[0]}};
    act_a = {seg_pkg::onehot(s_r.apos) ^ {4{s_r.an[0]}},
             u_if.dig ^ {4{s_r.an[1]}}};
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    s_nxt.cnt = tick ? 24'h00_0000 : s_r.cnt + 24'h00_0001;

    // bus answer, one cycle after the setup edge
    if (setup) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = !mapped;
      s_nxt.prdata = pwrite ? seg_pkg::RD_ZERO : rd;
    end

    // register writes land on the completing access edge
    if (acc && pwrite) begin
      case (paddr)
        seg_pkg::A_CTRL: begin
          s_nxt.drive = pwdata[seg_pkg::CB_DRIVE];
          s_nxt.pol = pwdata[seg_pkg::CB_POL];
          s_nxt.sink = pwdata[seg_pkg::CB_SINK];
          s_nxt.arw_en = pwdata[seg_pkg::CB_ARW];
          s_nxt.n = pwdata[seg_pkg::CB_N +: 3];
          s_nxt.an = pwdata[seg_pkg::CB_AN +: 2];
        end
        seg_pkg::A_SRC1: s_nxt.src1 = pwdata[15:0];
        seg_pkg::A_SRC2: s_nxt.src2 = pwdata[15:0];
        seg_pkg::A_SEGSRC: s_nxt.dst = {s_r.dst[15:8], u_if.seg};
        seg_pkg::A_SEGDST: s_nxt.dst = pwdata[15:0];
        seg_pkg::A_PERIOD: s_nxt.period = pwdata[23:0];
        default: s_nxt.period = s_r.period;
      endcase
    end

    // status clear by writing ones; a set below overrides it
    if (acc && pwrite && paddr == seg_pkg::A_STAT) begin
      if (pwdata[seg_pkg::SB_DONE]) begin
        s_nxt.done = 1'b0;
      end
      if (pwdata[seg_pkg::SB_ERR]) begin
        s_nxt.err = 1'b0;
      end
    end

    // display scan sequence
    case (s_r.st)
      seg_pkg::SC_IDLE: begin
        s_nxt.pos = 2'h0;
        s_nxt.g1 = {4{s_r.n[1]}};
        s_nxt.g2 = {4{s_r.n[1]}};
        s_nxt.strb = {4{s_r.n[0]}};
        if (s_r.drive) begin
          s_nxt.st = seg_pkg::SC_RUN;
        end
      end
      seg_pkg::SC_RUN: begin
        if (!s_r.drive) begin
          s_nxt.st = seg_pkg::SC_IDLE;
          s_nxt.pos = 2'h0;
        end else if (tick) begin
          s_nxt.g1 = act_d;
          s_nxt.g2 = s_r.n[2]
            ? seg_pkg::nib_at(bcd2, s_r.pos) ^ {4{s_r.n[1]}}
            : {4{s_r.n[1]}};
          s_nxt.strb = act_s;
          s_nxt.pos = s_r.pos + 2'h1;
          if (bad) begin
            s_nxt.err = 1'b1;
          end
          if (s_r.pos == 2'h3) begin
            s_nxt.done = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.st = seg_pkg::SC_IDLE;
      end
    endcase

    // arrow entry scan runs on the same computation cycle
    if (!s_r.arw_en) begin
      s_nxt.apos = 2'h0;
      s_nxt.arw = {{4{s_r.an[0]}}, {4{s_r.an[1]}}};
    end else if (tick) begin
      s_nxt.arw = act_a;
      s_nxt.apos = s_r.apos + 2'h1;
    end

    // pin levels registered with the output stage flip applied, so
    // no gate sits between a flop and a pin; a sinking stage pulls
    // low on internal one, a sourcing stage drives high
    s_nxt.pin_g1 = s_nxt.g1 ^ {4{s_nxt.sink}};
    s_nxt.pin_g2 = s_nxt.g2 ^ {4{s_nxt.sink}};
    s_nxt.pin_strb = s_nxt.strb ^ {4{s_nxt.sink}};
    s_nxt.pin_arw = s_nxt.arw ^ {8{s_nxt.sink}};
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_comb begin
    s_rst = '0;
    s_rst.st = seg_pkg::SC_IDLE;
    s_rst.period = SCAN_CYC[23:0];
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_r <= s_rst;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flops
  // ---------------------------------------------------------------
  // every pin is a plain copy of a state flop
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign group1_data_outputs = s_r.pin_g1;
  assign group2_data_outputs = s_r.pin_g2;
  assign digit_strobe_outputs = s_r.pin_strb;
  assign arrow_scan_outputs = s_r.pin_arw;
  assign sequence_done_flag = s_r.done;
  assign error_flag = s_r.err;
endmodule : latched_segment_display
`default_nettype wire

// ### sim/seg_chk.sv
// checker: display pin relations of the latched segment display
`timescale 1ns/1ns
`default_nettype none
module seg_chk #(
  parameter int unsigned SCAN_CYC = seg_pkg::SCAN_CYC // clocks per cycle
) (
  input wire logic clk_sys, // clock
  input wire logic srst, // reset
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // direction
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [3:0] key_in, // keys
  input wire logic [3:0] group1_data_outputs, // group 1
  input wire logic [3:0] group2_data_outputs, // group 2
  input wire logic [3:0] digit_strobe_outputs, // strobes
  input wire logic [7:0] arrow_scan_outputs, // arrow pins
  input wire logic sequence_done_flag, // done
  input wire logic error_flag // error
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // control shadow and decoded pins
  // ----------------------------------------
  logic [9:0] ctrl_r, ctrl_nxt;
  logic [1:0] age_r, age_nxt;
  logic [3:0] prev_r;
  logic [3:0] stb, g1, g2;
  logic ok, drv;
  // age masks the edges where pins follow a control write
  always_comb begin
    ctrl_nxt = ctrl_r;
    age_nxt = age_r[1] ? age_r : age_r + 2'd1;
    if (psel && penable && pready && pwrite && !pslverr && paddr == seg_pkg::A_CTRL) begin
      ctrl_nxt = pwdata[9:0];
      age_nxt = 2'd0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_r <= 10'h000;
      age_r <= 2'd2;
      prev_r <= 4'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      age_r <= age_nxt;
      prev_r <= stb;
    end
  end
  // strip sink and setting inversion back to internal levels
  assign ok = age_r[1];
  assign drv = ctrl_r[0];
  assign stb = digit_strobe_outputs ^ {4{ctrl_r[4] ^ ctrl_r[2]}};
  assign g1 = group1_data_outputs ^ {4{ctrl_r[5] ^ ctrl_r[2]}};
  assign g2 = group2_data_outputs ^ {4{ctrl_r[5] ^ ctrl_r[2]}};
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_idle_pins: assert property (ok && !drv |-> stb == 4'h0 && g1 == 4'h0)
    else $error("pins not idle with drive off");
  a_one_strobe: assert property (ok && drv && stb != 4'h0 |-> $onehot(stb))
    else $error("more than one strobe active");
  a_pos_step: assert property (ok && drv && prev_r != 4'h0 && stb != prev_r
    |-> stb == {prev_r[2:0], prev_r[3]})
    else $error("digit position skipped");
  a_first_pos: assert property (ok && drv && prev_r == 4'h0 && stb != 4'h0
    |-> stb == 4'h1)
    else $error("sequence did not start at units");
  a_done_last: assert property (ok && $rose(sequence_done_flag) |-> stb == 4'h8)
    else $error("done set before fourth digit");
  a_bcd_digit: assert property (ok && drv && stb != 4'h0 |-> g1 <= 4'h9 && g2 <= 4'h9)
    else $error("data digit above nine");
  a_group2_off: assert property (ok && !ctrl_r[6] |-> g2 == 4'h0)
    else $error("group 2 active in one-group mode");
  a_err_hold: assert property (error_flag && !(psel && penable && pwrite
    && paddr == seg_pkg::A_STAT && pwdata[1]) |=> error_flag)
    else $error("error flag lost without clear");
endmodule : seg_chk
`default_nettype wire

// ### sim/latched_monitor.sv
// partner: latched bcd monitor digits fed by data and strobe pins
`timescale 1ns/1ns
`default_nettype none
module latched_monitor (
  input wire logic clk_sys, // clock
  input wire logic [3:0] data_pin, // data pins
  input wire logic [3:0] strb_pin, // strobes
  input wire logic data_neg, // low level reads as one
  input wire logic strb_neg, // low strobe holds
  output logic [15:0] shown // held digits, units lowest
);
  logic [3:0] hold;
  logic [3:0] held_r = 4'hF;
  assign hold = strb_neg ? ~strb_pin : strb_pin;
  // a digit keeps what it saw as its strobe entered the hold level
  always @(posedge clk_sys) begin
    for (int k = 0; k < 4; k++) begin
      if (hold[k] && !held_r[k]) begin
        shown[4 * k +: 4] <= data_neg ? ~data_pin : data_pin;
      end
    end
    held_r <= hold;
  end
endmodule : latched_monitor
`default_nettype wire

// ### sim/testbench.sv
// testbench: registers, decoder, display sequence and arrow entry
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] key_in = 4'h0;
  logic dneg = 1'b0;
  logic sneg = 1'b0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, done, err;
  logic [3:0] g1, g2, stb;
  logic [7:0] arw;
  logic [15:0] shown1, shown2;
  int fail_count = 0;
  int samples_checked = 0;
  logic [6:0] seg_tab [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h27,
    7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
  // short computation cycle keeps the run small
  latched_segment_display #(.SCAN_CYC(4)) uut (
    .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_in(key_in), .group1_data_outputs(g1), .group2_data_outputs(g2),
    .digit_strobe_outputs(stb), .arrow_scan_outputs(arw), .sequence_done_flag(done),
    .error_flag(err));
  latched_monitor mon1 (.clk_sys(clk_sys), .data_pin(g1), .strb_pin(stb),
    .data_neg(dneg), .strb_neg(sneg), .shown(shown1));
  latched_monitor mon2 (.clk_sys(clk_sys), .data_pin(g2), .strb_pin(stb),
    .data_neg(dneg), .strb_neg(sneg), .shown(shown2));
  always #4 clk_sys = ~clk_sys;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // one apb transfer; request held until ready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk({31'h0, pready}, 32'h1, "no ready");
    if (n >= 20) print_verdict();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_done();
    int n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk({31'h0, done}, 32'h1, "done");
    if (n >= 200) print_verdict();
    repeat (2) @(negedge clk_sys);
  endtask : wait_done
  function automatic logic [15:0] bcd(input int v);
    return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction : bcd
  task automatic press(input logic [3:0] k);
    @(posedge clk_sys);
    key_in <= k;
    repeat (2) @(posedge clk_sys);
    key_in <= 4'h0;
    @(posedge clk_sys);
  endtask : press
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    apb(0, seg_pkg::A_PERIOD, '0);
    chk(rdat, 32'h0000_0004, "period reset");
    apb(1, 8'h20, 32'hFFFF_FFFF);
    chk({31'h0, rerr}, 32'h1, "unmapped error");
    apb(0, 8'h20, '0);
    chk(rdat, 32'h0000_0000, "unmapped data");
  endtask : t_regs
  task automatic t_decode();
    apb(1, seg_pkg::A_SEGDST, 32'h0000_AB55);
    for (int p = 0; p < 2; p++) begin
      apb(1, seg_pkg::A_CTRL, 32'(p) << 1);
      for (int h = 0; h < 16; h++) begin
        apb(1, seg_pkg::A_SEGSRC, 32'h0000_FFF0 | 32'(h));
        apb(0, seg_pkg::A_SEGDST, '0);
        chk(rdat, {16'h0, 8'hAB, p[0], seg_tab[h] ^ {7{p[0]}}}, "decode");
      end
    end
  endtask : t_decode
  task automatic t_display();
    logic [3:0] c;
    int a, b;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      a = 9999 - 611 * i;
      b = 1000 + 599 * i;
      dneg <= c[3] ^ c[1];
      sneg <= c[3] ^ c[0];
      apb(1, seg_pkg::A_SRC1, 32'(a));
      apb(1, seg_pkg::A_SRC2, 32'(b));
      apb(1, seg_pkg::A_CTRL, {25'h0, c[2:0], 1'b0, c[3], 2'b01});
      wait_done();
      chk({16'h0, shown1}, {16'h0, bcd(a)}, "group 1");
      if (c[2]) chk({16'h0, shown2}, {16'h0, bcd(b)}, "group 2");
      else chk({16'h0, shown2}, 32'h0, "group 2 off");
      chk({31'h0, err}, 32'h0, "error in range");
      apb(1, seg_pkg::A_CTRL, {25'h0, c[2:0], 1'b0, c[3], 2'b00});
      // run leaves at the first edge, pins go idle at the second
      repeat (3) @(negedge clk_sys);
      chk({28'h0, stb}, {28'h0, {4{c[3] ^ c[0]}}}, "strobe idle");
      chk({28'h0, g1}, {28'h0, {4{c[3] ^ c[1]}}}, "data idle");
      apb(1, seg_pkg::A_STAT, 32'h0000_0003);
      apb(0, seg_pkg::A_STAT, '0);
      chk({30'h0, rdat[1:0]}, 32'h0, "flags clear");
    end
  endtask : t_display
  task automatic t_error();
    for (int j = 0; j < 3; j++) begin
      apb(1, seg_pkg::A_SRC1, (j == 1) ? 32'h0000_2710 : 32'h0000_270F);
      apb(1, seg_pkg::A_SRC2, 32'h0000_2710);
      apb(1, seg_pkg::A_CTRL, (j == 2) ? 32'h0000_0041 : 32'h0000_0001);
      wait_done();
      chk({31'h0, err}, {31'h0, j != 0}, "error flag");
      apb(1, seg_pkg::A_CTRL, '0);
      apb(1, seg_pkg::A_STAT, 32'h0000_0003);
    end
  endtask : t_error
  task automatic t_restart();
    int n = 0;
    apb(1, seg_pkg::A_CTRL, 32'h0000_0001);
    repeat (9) @(negedge clk_sys);
    apb(1, seg_pkg::A_CTRL, '0);
    apb(0, seg_pkg::A_STAT, '0);
    chk({30'h0, rdat[5:4]}, 32'h0, "position reset");
    apb(1, seg_pkg::A_CTRL, 32'h0000_0001);
    while (stb === 4'h0 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    chk({28'h0, stb}, 32'h0000_0001, "first digit");
    if (n >= 20) print_verdict();
    apb(1, seg_pkg::A_CTRL, '0);
  endtask : t_restart
  task automatic t_arrow();
    int n = 0;
    apb(1, seg_pkg::A_CTRL, 32'h0000_0008);
    apb(1, seg_pkg::A_ARW, 32'h0000_0009);
    press(4'h4);
    press(4'h1);
    press(4'h8);
    press(4'h2);
    press(4'h4);
    repeat (3) press(4'h1);
    press(4'h4);
    apb(0, seg_pkg::A_ARW, '0);
    chk(rdat, 32'h0000_2900, "arrow word");
    apb(0, seg_pkg::A_STAT, '0);
    chk({30'h0, rdat[9:8]}, 32'h0, "arrow digit");
    // thousands strobe must carry the edited thousands digit
    while (arw[7:4] !== 4'h8 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    chk({24'h0, arw}, 32'h0000_0082, "arrow pins");
    if (n >= 20) print_verdict();
  endtask : t_arrow
  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs();
    t_decode();
    t_display();
    t_error();
    t_restart();
    t_arrow();
    print_verdict();
  end
endmodule : testbench
bind latched_segment_display seg_chk #(.SCAN_CYC(SCAN_CYC)) u_chk (
  .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .key_in(key_in), .group1_data_outputs(group1_data_outputs),
  .group2_data_outputs(group2_data_outputs), .digit_strobe_outputs(digit_strobe_outputs),
  .arrow_scan_outputs(arrow_scan_outputs), .sequence_done_flag(sequence_done_flag),
  .error_flag(error_flag));
`default_nettype wire
